// ===== src/dual_bank_olm.sv
// Top of the dual-bank output macrocell array with configuration port
`timescale 1ns/100ps
`default_nettype none
`include "olm_defs.svh"

module dual_bank_olm (
  input  wire logic        CLOCK,
  input  wire logic        RSTN,
  input  wire logic [20:0] IN_PINS,
  input  wire logic        CLK_A,
  input  wire logic        CLK_B,
  input  wire logic        TEST_STATE_LOAD,
  input  wire logic [7:0]  TEST_VALUE,
  input  wire logic [9:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  output logic      [7:0]  OUT_DATA,
  output logic      [7:0]  OUT_EN
);

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  logic [`OLM_N_LIT-1:0] fuse [0:`OLM_N_TERM-1]; // Product term masks
  logic [15:0]           cfg_mc;       // Mode and polarity bits
  olm_pkg::clk_cfg_t     cfg_clk;      // Bank clock selection
  logic [20:0]           in_s1;        // Input synchroniser stage 1
  logic [20:0]           in_s2;        // Input synchroniser stage 2
  logic [2:0]            clka_s;       // Clock A sync plus history
  logic [2:0]            clkb_s;       // Clock B sync plus history
  logic                  load_s1;      // Test load sync stage 1
  logic                  load_s2;      // Test load sync stage 2
  logic [7:0]            val_s1;       // Test value sync stage 1
  logic [7:0]            val_s2;       // Test value sync stage 2
  logic [7:0]            regs;         // Macrocell register states

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Connected literal ANDs in; unconnected column is a don't care
  function automatic logic pterm(input logic [`OLM_N_LIT-1:0] mask,
                                 input logic [`OLM_N_LIT-1:0] lits);
    pterm = &(~mask | lits);
  endfunction

  // First sum term of a macrocell
  function automatic int sum_base(input int m);
    if (m < `OLM_BANK_SIZE) begin
      sum_base = m * `OLM_PT_SMALL;
    end else begin
      sum_base = `OLM_LARGE_BASE + (m - `OLM_BANK_SIZE) * `OLM_PT_LARGE;
    end
  endfunction

  // Number of sum terms of a macrocell
  function automatic int sum_count(input int m);
    sum_count = (m < `OLM_BANK_SIZE) ? `OLM_PT_SMALL : `OLM_PT_LARGE;
  endfunction

  // Edge of a synchronised clock, either polarity
  function automatic logic edge_of(input logic cur, input logic prev,
                                   input logic fall);
    edge_of = fall ? (prev && !cur) : (cur && !prev);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Pins come from the board, so two flops before any logic
  always_ff @(posedge CLOCK) begin
    in_s1   <= IN_PINS;
    in_s2   <= in_s1;
    clka_s  <= {clka_s[1:0], CLK_A};
    clkb_s  <= {clkb_s[1:0], CLK_B};
    load_s1 <= TEST_STATE_LOAD;
    load_s2 <= load_s1;
    val_s1  <= TEST_VALUE;
    val_s2  <= val_s1;
  end

  // ----------------------------------------------------------------
  // Logic array
  // ----------------------------------------------------------------
  logic [`OLM_N_LIT-1:0] lits;         // True then complement columns
  logic [7:0]            sum;          // OR of each cell's terms
  logic [7:0]            next_oe;      // Enable per output
  olm_pkg::bank_ctl_t    ctl [0:1];    // Control terms per bank

  // Every input offered true and complemented
  assign lits = {~in_s2, in_s2};

  // Sum of products: twelve terms low bank, sixteen high bank
  always_comb begin
    for (int m = 0; m < `OLM_N_MC; m++) begin
      sum[m] = 1'b0;
      for (int j = 0; j < `OLM_PT_LARGE; j++) begin
        if (j < sum_count(m)) begin
          sum[m] = sum[m] | pterm(fuse[sum_base(m) + j], lits);
        end
      end
    end
  end

  // Two dedicated enable terms per output, ORed
  always_comb begin
    for (int m = 0; m < `OLM_N_MC; m++) begin
      next_oe[m] = pterm(fuse[`OLM_OE_BASE + 2 * m], lits) |
                   pterm(fuse[`OLM_OE_BASE + 2 * m + 1], lits);
    end
  end

  // One preset and one reset term per bank
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      ctl[b].preset = pterm(fuse[`OLM_PRE_BASE + b], lits);
      ctl[b].areset = pterm(fuse[`OLM_AR_BASE + b], lits);
    end
  end

  // ----------------------------------------------------------------
  // Bank clocking
  // ----------------------------------------------------------------
  logic [1:0] edge_hit;   // Active edge seen per bank
  logic       src1_cur;   // Bank 1 clock source, current
  logic       src1_prev;  // Bank 1 clock source, previous

  // Shared clock lets bank 1 follow clock A
  assign src1_cur  = cfg_clk.common ? clka_s[1] : clkb_s[1];
  assign src1_prev = cfg_clk.common ? clka_s[2] : clkb_s[2];
  assign edge_hit[0] = edge_of(clka_s[1], clka_s[2], cfg_clk.fall0);
  assign edge_hit[1] = edge_of(src1_cur, src1_prev, cfg_clk.fall1);

  // ----------------------------------------------------------------
  // Macrocells
  // ----------------------------------------------------------------
  olm_pkg::mc_cfg_t mcfg [0:7];   // Unpacked view of mode bits

  // Four cells per bank share the bank's edge and control terms
  for (genvar m = 0; m < `OLM_N_MC; m++) begin : g_mc
    assign mcfg[m].comb     = cfg_mc[`OLM_F_COMB_LO + m];
    assign mcfg[m].act_high = cfg_mc[`OLM_F_POL_LO + m];
    olm_macrocell u_mc (
      .clock    (CLOCK),
      .rstn     (RSTN),
      .cfg      (mcfg[m]),
      .sum      (sum[m]),
      .edge_hit (edge_hit[m / `OLM_BANK_SIZE]),
      .ctl      (ctl[m / `OLM_BANK_SIZE]),
      .load     (load_s2),
      .load_val (val_s2[m]),
      .state    (regs[m]),
      .pin      (OUT_DATA[m])
    );
  end

  assign OUT_EN = next_oe;

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  logic        wr_fuse;      // Write lands in the fuse array
  logic        wr_mc;        // Write to mode register
  logic        wr_clk;       // Write to clock register
  logic [7:0]  fuse_idx;     // Term addressed by the port
  logic [31:0] fuse_word;    // Readback of the addressed half
  logic [31:0] next_rdata;   // Read data for next cycle

  assign wr_fuse  = WR && (ADDR < `OLM_FUSE_WORDS);
  assign wr_mc    = WR && (ADDR == `OLM_ADDR_CFG_MC);
  assign wr_clk   = WR && (ADDR == `OLM_ADDR_CFG_CLK);
  assign fuse_idx = ADDR[8:1];
  // Index is only used when in range, so clamp for readback safety
  assign fuse_word = (ADDR >= `OLM_FUSE_WORDS) ? 32'h0 :
                     ADDR[0] ? {22'h0, fuse[fuse_idx][`OLM_N_LIT-1:
                                                      `OLM_LO_W]} :
                               fuse[fuse_idx][`OLM_LO_W-1:0];

  // Unmapped reads answer zero
  assign next_rdata =
    !RD                            ? 32'h0 :
    (ADDR < `OLM_FUSE_WORDS)       ? fuse_word :
    (ADDR == `OLM_ADDR_CFG_MC)     ? {16'h0, cfg_mc} :
    (ADDR == `OLM_ADDR_CFG_CLK)    ? {29'h0, cfg_clk} :
    (ADDR == `OLM_ADDR_STATUS)     ? {8'h0, regs, next_oe, OUT_DATA} :
                                     32'h0;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Reset leaves every fuse intact: all terms false, outputs float
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      for (int t = 0; t < `OLM_N_TERM; t++) begin
        fuse[t] <= `OLM_FUSE_RST;
      end
    end else if (wr_fuse && ADDR[0]) begin
      fuse[fuse_idx][`OLM_N_LIT-1:`OLM_LO_W] <= WDATA[`OLM_HI_W-1:0];
    end else if (wr_fuse) begin
      fuse[fuse_idx][`OLM_LO_W-1:0] <= WDATA;
    end
  end

  // Mode and clock registers
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      cfg_mc  <= `OLM_CFG_MC_RST;
      cfg_clk <= `OLM_CFG_CLK_RST;
    end else begin
      if (wr_mc) begin
        cfg_mc <= WDATA[15:0];
      end
      if (wr_clk) begin
        cfg_clk <= WDATA[`OLM_F_CLK_LO +: `OLM_CLK_W];
      end
    end
  end

  // Read data stands one cycle only
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      RDATA <= 32'h0;
    end else begin
      RDATA <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence rise_a;
    !CLK_A ##1 CLK_A;
  endsequence

  sequence quiet_bank0;
    !ctl[0].areset && !load_s2 && !WR;
  endsequence

  AST_RESET_CLEAR: assert property (@(posedge CLOCK)
    !RSTN |=> regs == 8'h00)
    else $error("Registers not cleared by reset");

  AST_EDGE_DELAY: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (rise_a ##0 (!cfg_clk.fall0 && !WR)) |-> ##2 edge_hit[0])
    else $error("Bank 0 rising edge not seen two cycles on");

  AST_COMMON_CLK: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (cfg_clk.common && cfg_clk.fall0 == cfg_clk.fall1)
      |-> edge_hit[1] == edge_hit[0])
    else $error("Shared clock banks disagree");

  AST_BANK_PRESET: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (edge_hit[0] && ctl[0].preset ##0 quiet_bank0) |=> regs[3:0] == 4'hf)
    else $error("Bank 0 preset did not load high");

  AST_BANK_ARESET: assert property (@(posedge CLOCK) disable iff (!RSTN)
    ctl[1].areset[*2] |-> regs[7:4] == 4'h0)
    else $error("Bank 1 reset term left a register high");

  AST_TEST_LOAD: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (load_s2 && !ctl[0].areset && !ctl[1].areset) |=> regs == $past(val_s2))
    else $error("Test load value not taken");

  AST_OE_TERMS: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (fuse[`OLM_OE_BASE] == 42'h0) |-> OUT_EN[0])
    else $error("Always-true enable term did not drive output");

  AST_READ_ONE: assert property (@(posedge CLOCK) disable iff (!RSTN)
    (RD && ADDR == `OLM_ADDR_CFG_MC && !WR) |=>
      (RDATA == {16'h0, cfg_mc}) ##1 (!$past(RD) -> RDATA == 32'h0))
    else $error("Mode register readback wrong or held too long");

  // Read data fall back to zero once the strobe is gone
  AST_RDATA_IDLE: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    !RD |=> RDATA == 32'h0)
    else $error("Read data stood without a read strobe");

  // Status readback shows the register states of the strobe cycle
  AST_STATUS_READ: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (RD && ADDR == `OLM_ADDR_STATUS) |=> RDATA[23:16] == $past(regs))
    else $error("Status readback lost the register states");

  // Bank 1 must ignore activity that belongs to bank 0
  AST_BANK_HOLD: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (!edge_hit[1] && !ctl[1].areset && !load_s2) |=> $stable(regs[7:4]))
    else $error("Bank 1 registers moved without a bank 1 edge");

  // Intact enable terms are false, so the output floats
  AST_OE_OFF: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    (fuse[`OLM_OE_BASE] == `OLM_FUSE_RST &&
     fuse[`OLM_OE_BASE + 1] == `OLM_FUSE_RST) |-> !OUT_EN[0])
    else $error("Output driven with both enable terms false");

  // Bank 0 reset term clears its registers within one clock
  AST_BANK0_ARESET: assert property (
    @(posedge CLOCK) disable iff (!RSTN)
    ctl[0].areset[*2] |-> regs[3:0] == 4'h0)
    else $error("Bank 0 reset term left a register high");

endmodule

`default_nettype wire

// ===== src/olm_defs.svh
// Constants shared by the dual-bank output macrocell design
`ifndef OLM_DEFS_SVH
`define OLM_DEFS_SVH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define OLM_N_IN        21
`define OLM_N_LIT       42
`define OLM_N_MC        8
`define OLM_BANK_SIZE   4
`define OLM_PT_SMALL    12
`define OLM_PT_LARGE    16
`define OLM_LARGE_BASE  48
`define OLM_OE_BASE     112
`define OLM_PRE_BASE    128
`define OLM_AR_BASE     130
`define OLM_N_TERM      132

// ----------------------------------------------------------------
// Register map (word addresses on the plain port)
// ----------------------------------------------------------------
`define OLM_FUSE_WORDS   10'h108
`define OLM_ADDR_CFG_MC  10'h200
`define OLM_ADDR_CFG_CLK 10'h201
`define OLM_ADDR_STATUS  10'h202

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define OLM_LO_W        32
`define OLM_HI_W        10
`define OLM_F_COMB_LO   0
`define OLM_F_POL_LO    8
`define OLM_F_CLK_LO    0
`define OLM_CLK_W       3
`define OLM_FUSE_RST    42'h3ffffffffff
`define OLM_CFG_MC_RST  16'h0000
`define OLM_CFG_CLK_RST 3'h0

`endif

// ===== src/olm_pkg.sv
// Types shared by the dual-bank output macrocell design
package olm_pkg;

  // Per-macrocell configuration
  typedef struct packed {
    logic comb;      // 1: combinatorial, 0: registered
    logic act_high;  // 1: active high output
  } mc_cfg_t;

  // Bank clocking configuration
  typedef struct packed {
    logic fall1;     // Bank 1 acts on falling edge
    logic fall0;     // Bank 0 acts on falling edge
    logic common;    // Bank 1 follows bank 0 clock
  } clk_cfg_t;

  // Per-bank control product terms
  typedef struct packed {
    logic preset;    // Synchronous preset term
    logic areset;    // Asynchronous reset term
  } bank_ctl_t;

endpackage

// ===== src/olm_macrocell.sv
// One output logic macrocell: state register, mode and polarity select
`timescale 1ns/100ps
`default_nettype none

module olm_macrocell (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire olm_pkg::mc_cfg_t  cfg,
  input  wire logic              sum,
  input  wire logic              edge_hit,
  input  wire olm_pkg::bank_ctl_t ctl,
  input  wire logic              load,
  input  wire logic              load_val,
  output logic                   state,
  output logic                   pin
);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic next_state;   // Value taken at the next clock
  logic raw;          // Level before polarity

  // Reset term beats everything, so a stuck tester cannot mask it
  assign next_state = ctl.areset ? 1'b0 :
                      load       ? load_val :
                      !edge_hit  ? state :
                      ctl.preset ? 1'b1 : sum;

  // Register; cleared by reset so power-up state is known
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Output path
  // ----------------------------------------------------------------
  // Reset term also masks the register combinationally: no clock wait
  assign raw = cfg.comb ? sum :
               (ctl.areset ? 1'b0 : state);
  assign pin = cfg.act_high ? raw : ~raw;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence preset_edge;
    edge_hit && ctl.preset && !ctl.areset && !load;
  endsequence

  AST_MC_PRESET: assert property (@(posedge clock) disable iff (!rstn)
    preset_edge |=> state)
    else $error("Preset edge did not set register");
  AST_MC_ARESET: assert property (@(posedge clock) disable iff (!rstn)
    ctl.areset |-> (!cfg.comb -> pin == !cfg.act_high) ##1 !state)
    else $error("Reset term did not force register low");
  AST_MC_HOLD: assert property (@(posedge clock) disable iff (!rstn)
    (!edge_hit && !ctl.areset && !load) |=> $stable(state))
    else $error("Register changed without active edge");
  AST_MC_COMB: assert property (@(posedge clock) disable iff (!rstn)
    cfg.comb |-> pin == (cfg.act_high ? sum : !sum))
    else $error("Combinatorial output differs from sum");

endmodule

`default_nettype wire

// ===== tb/board_model.sv
// Board-side model that drives the two bank clock pins on request
`timescale 1ns/100ps
`default_nettype none

module board_model (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic want_a,
  input  wire logic want_b,
  output logic      clk_a,
  output logic      clk_b
);
  // --------------------------------------------------------------
  // Clock pin generation
  // --------------------------------------------------------------
  logic [2:0] hold_a;  // Cycles since pin A last moved
  logic [2:0] hold_b;  // Cycles since pin B last moved

  // Pins stand still between requests; each level is held at least
  // two cycles because the device samples the pins with its clock
  always_ff @(posedge clock) begin
    if (!rstn) begin
      clk_a  <= 1'b0;
      clk_b  <= 1'b0;
      hold_a <= 3'h0;
      hold_b <= 3'h0;
    end else begin
      if (want_a != clk_a && hold_a >= 3'h2) begin
        clk_a  <= want_a;
        hold_a <= 3'h0;
      end else if (hold_a != 3'h7) begin
        hold_a <= hold_a + 3'h1;
      end
      if (want_b != clk_b && hold_b >= 3'h2) begin
        clk_b  <= want_b;
        hold_b <= 3'h0;
      end else if (hold_b != 3'h7) begin
        hold_b <= hold_b + 3'h1;
      end
    end
  end
endmodule

`default_nettype wire

// ===== tb/dual_bank_olm_bench.sv
// Self-checking bench for the dual-bank output macrocell array
`timescale 1ns/100ps
`default_nettype none
`include "olm_defs.svh"

module dual_bank_olm_bench;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic        CLOCK;           // System clock
  logic        RSTN;            // Synchronous reset, low active
  logic [20:0] IN_PINS;         // Array inputs
  logic        CLK_A;           // Bank 0 clock pin from board
  logic        CLK_B;           // Bank 1 clock pin from board
  logic        TEST_STATE_LOAD; // Tester load strobe
  logic [7:0]  TEST_VALUE;      // Tester load value
  logic [9:0]  ADDR;            // Port address
  logic [31:0] WDATA;           // Port write data
  logic        WR;              // Write strobe
  logic        RD;              // Read strobe
  logic [31:0] RDATA;           // Port read data
  logic [7:0]  OUT_DATA;        // Output levels
  logic [7:0]  OUT_EN;          // Output drive enables
  logic        want_a;          // Requested level of pin A
  logic        want_b;          // Requested level of pin B
  logic [31:0] got;             // Last read value
  int          num_errors;      // Mismatch count
  int          comparisons;     // Comparison count

  dual_bank_olm u_dual_bank_olm (.CLOCK(CLOCK), .RSTN(RSTN),
    .IN_PINS(IN_PINS), .CLK_A(CLK_A), .CLK_B(CLK_B),
    .TEST_STATE_LOAD(TEST_STATE_LOAD), .TEST_VALUE(TEST_VALUE),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .OUT_DATA(OUT_DATA), .OUT_EN(OUT_EN));

  board_model u_board_model (.clock(CLOCK), .rstn(RSTN),
    .want_a(want_a), .want_b(want_b), .clk_a(CLK_A), .clk_b(CLK_B));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("Counts: %0d compared, %0d bad", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Clock edges to let synchronisers and logic settle
  task automatic settle(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask

  // Array inputs change only right after a rising edge
  task automatic drive(input logic [20:0] v);
    @(posedge CLOCK);
    IN_PINS <= v;
  endtask

  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    WR    <= 1'b1;
    ADDR  <= a;
    WDATA <= d;
    @(posedge CLOCK);
    WR    <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe edge
  task automatic rd(input logic [9:0] a);
    @(posedge CLOCK);
    RD   <= 1'b1;
    ADDR <= a;
    @(posedge CLOCK);
    RD   <= 1'b0;
    #1;
    got = RDATA;
  endtask

  // One product term: low mask word, then high mask word
  task automatic term(input int k, input logic [41:0] m);
    wr(10'(2 * k), m[31:0]);
    wr(10'(2 * k + 1), {22'h0, m[41:32]});
  endtask

  task automatic regs_is(input string what, input logic [7:0] exp);
    rd(`OLM_ADDR_STATUS);
    check(what, {24'h0, exp}, {24'h0, got[23:16]});
  endtask

  // Move a board clock pin and wait for the device to react
  task automatic pin(input logic b, input logic lvl);
    if (b) want_b <= lvl;
    else want_a <= lvl;
    settle(8);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset;
    rd(`OLM_ADDR_CFG_MC);
    check("cfg_mc", 32'h0, got);
    rd(`OLM_ADDR_STATUS);
    check("status", 32'h000000ff, got);
    $display("test reset done");
  endtask

  task automatic t_port;
    wr(`OLM_ADDR_STATUS, 32'hffffffff);
    rd(`OLM_ADDR_STATUS);
    check("status ro", 32'h000000ff, got);
    wr(10'h3ff, 32'h12345678);
    rd(10'h3ff);
    check("unmapped", 32'h0, got);
    wr(`OLM_ADDR_CFG_CLK, 32'h7);
    rd(`OLM_ADDR_CFG_CLK);
    check("cfg_clk", 32'h7, got);
    wr(`OLM_ADDR_CFG_CLK, 32'h0);
    $display("test port done");
  endtask

  task automatic t_enable;
    term(112, 42'h1);
    term(113, 42'h2);
    for (int i = 0; i < 4; i++) begin
      drive(21'(i));
      settle(3);
      check("out_en", {31'h0, i != 0}, {24'h0, OUT_EN});
    end
    // A term with no input connected is always true
    term(112, 42'h0);
    settle(1);
    check("out_en true", 32'h1, {24'h0, OUT_EN});
    drive(21'h0);
    $display("test enable done");
  endtask

  task automatic t_comb;
    wr(`OLM_ADDR_CFG_MC, 32'h2311);
    term(11, 42'h4);
    term(63, 42'h20000000000);
    settle(3);
    check("comb low", 32'hcc, {24'h0, OUT_DATA});
    drive(21'h100004);
    settle(3);
    check("comb high", 32'hdd, {24'h0, OUT_DATA});
    drive(21'h0);
    $display("test comb done");
  endtask

  task automatic t_clocks;
    term(12, 42'h10);
    term(64, 42'h10);
    drive(21'h10);
    pin(1'b0, 1'b1);
    pin(1'b0, 1'b0);
    regs_is("bank0 own", 8'h02);
    pin(1'b1, 1'b1);
    pin(1'b1, 1'b0);
    regs_is("bank1 own", 8'h32);
    drive(21'h0);
    wr(`OLM_ADDR_CFG_CLK, 32'h1);
    pin(1'b1, 1'b1);
    pin(1'b1, 1'b0);
    regs_is("common b", 8'h32);
    pin(1'b0, 1'b1);
    pin(1'b0, 1'b0);
    regs_is("common a", 8'h10);
    wr(`OLM_ADDR_CFG_CLK, 32'h2);
    drive(21'h10);
    pin(1'b0, 1'b1);
    regs_is("fall rise", 8'h10);
    pin(1'b0, 1'b0);
    regs_is("fall fall", 8'h12);
    $display("test clocks done");
  endtask

  task automatic t_controls;
    wr(`OLM_ADDR_CFG_CLK, 32'h0);
    term(128, 42'h20);
    term(130, 42'h40);
    drive(21'h20);
    pin(1'b0, 1'b1);
    regs_is("preset", 8'h1f);
    pin(1'b0, 1'b0);
    check("preset out", 32'hc2, {24'h0, OUT_DATA});
    drive(21'h40);
    settle(3);
    check("reset out", 32'hcc, {24'h0, OUT_DATA});
    regs_is("reset regs", 8'h10);
    drive(21'h0);
    $display("test controls done");
  endtask

  task automatic t_load;
    @(posedge CLOCK);
    TEST_VALUE      <= 8'ha5;
    TEST_STATE_LOAD <= 1'b1;
    settle(4);
    @(posedge CLOCK);
    TEST_STATE_LOAD <= 1'b0;
    settle(3);
    regs_is("load", 8'ha5);
    $display("test load done");
  endtask

  // --------------------------------------------------------------
  // Clock, watchdog and main sequence
  // --------------------------------------------------------------
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end

  // Cuts a hang short and counts it as a mismatch
  initial begin
    #200000;
    num_errors++;
    final_report();
  end

  initial begin
    num_errors = 0;
    comparisons = 0;
    RSTN = 1'b0;
    IN_PINS = 21'h0;
    TEST_STATE_LOAD = 1'b0;
    TEST_VALUE = 8'h0;
    ADDR = 10'h0;
    WDATA = 32'h0;
    WR = 1'b0;
    RD = 1'b0;
    want_a = 1'b0;
    want_b = 1'b0;
    repeat (4) @(posedge CLOCK);
    RSTN <= 1'b1;
    settle(3);
    t_reset();
    t_port();
    t_enable();
    t_comb();
    t_clocks();
    t_controls();
    t_load();
    final_report();
  end
endmodule

`default_nettype wire
